// ==== inc/lsae_pkg.sv ====
// constants and types for the load/store alignment and endian block
// Function
// - byte addresses are unsigned 32-bit values in one flat 4GB byte space
// - word-aligned means divisible by 4; word holds bytes A..A+3
// - halfword-aligned means divisible by 2; halfword holds bytes A, A+1
// - all address arithmetic wraps modulo two to the 32, never an error
// - top region is execute-never; fetching there reports an access violation
// - multiple transfers step upward by 4 per register
// - no unaligned data access is ever performed; it faults instead
// - unaligned base for load/store multiple, push or pop faults
// - halfword loads and stores not halfword-aligned fault
// - word loads and stores not word-aligned fault
// - fetches are always halfword-aligned, never at an odd address
// - exception entry through a vector with bit 0 clear gives invalid state
// - add or move writing the program counter ignores bit 0
// - branch exchange, branch link exchange or pop with bit 0 zero gives invalid state
// - executing in invalid state gives hard fault exception or lockup
// - little-endian puts the element at A in the least significant lane
// - big-endian puts the element at A in the most significant lane
// - word access touches the same four bytes; only lane order changes
// - endianness is fixed or sampled from an input at reset
// - endianness affects data only; instructions are always little-endian
// - private peripheral region accesses are always little-endian; multiple loads map each word but the last with the next beat's byte order
// - lane mapping works at the element size of each transfer
package lsae_pkg;
  // ==========================================
  // address space
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] EXEC_NEVER_BASE_DEF = 32'hF000_0000;
  localparam logic [31:0] PERIPH_BASE_DEF = 32'hE000_0000;
  localparam logic [31:0] PERIPH_LAST_DEF = 32'hE00F_FFFF;
  // ==========================================
  // element sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // ==========================================
  // program counter write sources
  localparam logic [1:0] PCSRC_ALU = 2'h0;
  localparam logic [1:0] PCSRC_XCHG = 2'h1;
  localparam logic [1:0] PCSRC_VEC = 2'h2;
  // ==========================================
  // reset values and widths
  localparam int CNT_W = 5;
  localparam logic RST_BIG = 1'b0;
  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } lsae_state_t;
endpackage

// ==== rtl/lsae_lane.sv ====
// byte lane mapper between register view and bus lanes
`timescale 1ns/1ps
module lsae_lane
  import lsae_pkg::*;
#(
  parameter bit LOAD = 1'b0
) (
  // element in
  input wire logic [31:0] data_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] lo_i,
  input wire logic big_i,
  input wire logic sign_i,
  // mapped out
  output logic [31:0] data_o
);
  logic [31:0] sh;
  logic [15:0] hw;

  // stores swap within the element when big-endian, then place the lane; loads extract the lane, then swap
  always_comb begin
    sh = 32'h0000_0000;
    hw = 16'h0000;
    data_o = data_i;
    if (!LOAD) begin
      case (size_i)
        SZ_BYTE: data_o = 32'(data_i[7:0]) << {lo_i, 3'b000};
        SZ_HALF: begin
          hw = big_i ? {data_i[7:0], data_i[15:8]} : data_i[15:0];
          data_o = 32'(hw) << {lo_i[1], 4'h0};
        end
        default: data_o = big_i ? {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]} : data_i;
      endcase
    end else begin
      sh = data_i >> {lo_i, 3'b000};
      case (size_i)
        SZ_BYTE: data_o = sign_i ? {{24{sh[7]}}, sh[7:0]} : {24'h00_0000, sh[7:0]};
        SZ_HALF: begin
          hw = big_i ? {sh[7:0], sh[15:8]} : sh[15:0];
          data_o = sign_i ? {{16{hw[15]}}, hw} : {16'h0000, hw};
        end
        default: data_o = big_i ? {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]} : data_i;
      endcase
    end
  end
endmodule

// ==== rtl/lsae_core.sv ====
// load/store alignment check, endian lane mapping, fetch and pc checks
`timescale 1ns/1ps
module lsae_core
  import lsae_pkg::*;
#(
  parameter bit ENDIAN_FIXED = 1'b0,
  parameter bit FIXED_BIG = 1'b0,
  parameter logic [31:0] EXEC_NEVER_BASE = EXEC_NEVER_BASE_DEF,
  parameter logic [31:0] PERIPH_BASE = PERIPH_BASE_DEF,
  parameter logic [31:0] PERIPH_LAST = PERIPH_LAST_DEF
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // endian strap pin
  input wire logic endian_big_i,
  // data request from pipeline
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_multi_i,
  input wire logic req_signed_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_base_i,
  input wire logic [31:0] req_offset_i,
  input wire logic [CNT_W-1:0] req_count_i,
  input wire logic [31:0] wdata_i,
  output logic req_ready_o,
  output logic [CNT_W-1:0] beat_o,
  // load result and alignment fault
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic align_fault_o,
  output logic [31:0] fault_addr_o,
  // system bus
  output logic bus_valid_o,
  output logic bus_write_o,
  output logic [31:0] bus_addr_o,
  output logic [1:0] bus_size_o,
  output logic [3:0] bus_be_o,
  output logic [31:0] bus_wdata_o,
  input wire logic bus_ready_i,
  input wire logic bus_rvalid_i,
  input wire logic [31:0] bus_rdata_i,
  // instruction fetch
  input wire logic fetch_req_i,
  input wire logic [31:0] fetch_pc_i,
  input wire logic fetch_rvalid_i,
  input wire logic [31:0] fetch_rdata_i,
  output logic fetch_valid_o,
  output logic [31:0] fetch_addr_o,
  output logic fetch_fault_o,
  output logic instr_valid_o,
  output logic [31:0] instr_o,
  // program counter writes and execution
  input wire logic pc_wr_i,
  input wire logic [1:0] pc_src_i,
  input wire logic [31:0] pc_val_i,
  input wire logic exec_i,
  input wire logic in_hard_fault_i,
  output logic pc_valid_o,
  output logic [31:0] pc_o,
  output logic invalid_state_o,
  output logic hard_fault_o,
  output logic lockup_o,
  output logic big_endian_o
);
  // ==========================================
  // state
  typedef struct packed {
    lsae_state_t state;
    logic end_s1;
    logic end_s2;
    logic big;
    logic ready;
    logic bus_valid;
    logic bus_write;
    logic [31:0] bus_addr;
    logic [1:0] bus_size;
    logic [3:0] bus_be;
    logic [31:0] bus_wdata;
    logic [CNT_W-1:0] left;
    logic [CNT_W-1:0] beat;
    logic [1:0] ld_size;
    logic [1:0] ld_lo;
    logic ld_big;
    logic ld_sign;
    logic rd_valid;
    logic [31:0] rd_data;
    logic fault;
    logic [31:0] fault_addr;
    logic fetch_valid;
    logic [31:0] fetch_addr;
    logic fetch_fault;
    logic instr_valid;
    logic [31:0] instr;
    logic pc_valid;
    logic [31:0] pc;
    logic invalid;
    logic hard_fault;
    logic lockup;
  } lsae_regs_t;

  lsae_regs_t st_reg;
  lsae_regs_t st_next;

  // ==========================================
  // address and check terms
  logic [31:0] eff_addr;
  logic [31:0] step_addr;
  logic idle;
  logic misalign;
  logic [31:0] st_addr;
  logic st_big;
  logic [1:0] st_size;
  logic [31:0] st_lanes;
  logic [31:0] ld_value;

  // effective and stepped addresses wrap at the top of the 4GB space
  assign eff_addr = ADDR_W'(req_base_i + req_offset_i);
  assign step_addr = ADDR_W'(st_reg.bus_addr + WORD_STEP);
  assign idle = (st_reg.state == ST_IDLE);

  // natural alignment per element size; multiples need a word base
  always_comb begin
    misalign = 1'b0;
    if (req_multi_i) begin
      misalign = (eff_addr[1:0] != 2'b00);
    end else if (req_size_i == SZ_HALF) begin
      misalign = eff_addr[0];
    end else if (req_size_i != SZ_BYTE) begin
      misalign = (eff_addr[1:0] != 2'b00);
    end
  end

  // store lane mapping input: new request while idle, next beat otherwise
  assign st_addr = idle ? eff_addr : step_addr;
  assign st_size = (idle && !req_multi_i) ? req_size_i : SZ_WORD;
  assign st_big = st_reg.big && !((st_addr >= PERIPH_BASE) && (st_addr <= PERIPH_LAST));

  lsae_lane #(
    .LOAD(1'b0)
  ) u_store_lane (
    .data_i(wdata_i),
    .size_i(st_size),
    .lo_i(st_addr[1:0]),
    .big_i(st_big),
    .sign_i(1'b0),
    .data_o(st_lanes)
  );

  lsae_lane #(
    .LOAD(1'b1)
  ) u_load_lane (
    .data_i(bus_rdata_i),
    .size_i(st_reg.ld_size),
    .lo_i(st_reg.ld_lo),
    .big_i(st_reg.ld_big),
    .sign_i(st_reg.ld_sign),
    .data_o(ld_value)
  );

  // ==========================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.fault = 1'b0;
    st_next.fetch_valid = 1'b0;
    st_next.fetch_fault = 1'b0;
    st_next.instr_valid = 1'b0;
    st_next.pc_valid = 1'b0;
    st_next.hard_fault = 1'b0;
    // strap synchroniser
    st_next.end_s1 = endian_big_i;
    st_next.end_s2 = st_reg.end_s1;

    // bus beat taken: step to the next word or finish
    if (st_reg.bus_valid && bus_ready_i) begin
      if (st_reg.left != '0) begin
        st_next.bus_addr = step_addr;
        st_next.bus_wdata = st_lanes;
        st_next.left = CNT_W'(st_reg.left - 1'b1);
        st_next.beat = CNT_W'(st_reg.beat + 1'b1);
        st_next.ld_big = st_big;
      end else begin
        st_next.bus_valid = 1'b0;
        st_next.state = ST_IDLE;
      end
    end

    // new data request: faults never reach the bus
    if (idle && req_valid_i) begin
      if (misalign) begin
        st_next.fault = 1'b1;
        st_next.fault_addr = eff_addr;
      end else if (!req_multi_i || (req_count_i != '0)) begin
        st_next.state = ST_BUSY;
        st_next.bus_valid = 1'b1;
        st_next.bus_write = req_write_i;
        st_next.bus_addr = eff_addr;
        st_next.bus_size = st_size;
        st_next.bus_wdata = st_lanes;
        st_next.left = req_multi_i ? CNT_W'(req_count_i - 1'b1) : '0;
        st_next.beat = '0;
        st_next.ld_size = st_size;
        st_next.ld_lo = eff_addr[1:0];
        st_next.ld_big = st_big;
        st_next.ld_sign = req_signed_i && !req_multi_i;
        case (st_size)
          SZ_BYTE: st_next.bus_be = 4'(4'h1 << eff_addr[1:0]);
          SZ_HALF: st_next.bus_be = 4'(4'h3 << {eff_addr[1], 1'b0});
          default: st_next.bus_be = 4'hF;
        endcase
      end
    end
    st_next.ready = (st_next.state == ST_IDLE);

    // load data returned from the bus
    if (bus_rvalid_i) begin
      st_next.rd_valid = 1'b1;
      st_next.rd_data = ld_value;
    end

    // instruction fetch, bit 0 forced low and execute-never top region
    if (fetch_req_i) begin
      if (fetch_pc_i >= EXEC_NEVER_BASE) begin
        st_next.fetch_fault = 1'b1;
      end else begin
        st_next.fetch_valid = 1'b1;
        st_next.fetch_addr = {fetch_pc_i[31:1], 1'b0};
      end
    end
    if (fetch_rvalid_i) begin
      st_next.instr_valid = 1'b1;
      st_next.instr = fetch_rdata_i;
    end

    // program counter writes and the invalid execution state
    if (pc_wr_i) begin
      st_next.pc_valid = 1'b1;
      st_next.pc = {pc_val_i[31:1], 1'b0};
      case (pc_src_i)
        PCSRC_ALU: st_next.invalid = 1'b0;
        PCSRC_XCHG: st_next.invalid = !pc_val_i[0];
        PCSRC_VEC: st_next.invalid = !pc_val_i[0];
        default: st_next.invalid = st_reg.invalid;
      endcase
    end
    if (exec_i && st_reg.invalid) begin
      if (in_hard_fault_i) begin
        st_next.lockup = 1'b1;
      end else begin
        st_next.hard_fault = 1'b1;
      end
    end

    // reset: endianness fixed or captured from the synchronised strap
    if (!resetn_i) begin
      st_next = '0;
      st_next.state = ST_IDLE;
      st_next.ready = 1'b1;
      st_next.end_s1 = endian_big_i;
      st_next.end_s2 = st_reg.end_s1;
      st_next.big = ENDIAN_FIXED ? FIXED_BIG : st_reg.end_s2;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clock_i) begin
    st_reg <= st_next;
  end

  // ==========================================
  // outputs
  assign req_ready_o = st_reg.ready;
  assign beat_o = st_reg.beat;
  assign rd_valid_o = st_reg.rd_valid;
  assign rd_data_o = st_reg.rd_data;
  assign align_fault_o = st_reg.fault;
  assign fault_addr_o = st_reg.fault_addr;
  assign bus_valid_o = st_reg.bus_valid;
  assign bus_write_o = st_reg.bus_write;
  assign bus_addr_o = st_reg.bus_addr;
  assign bus_size_o = st_reg.bus_size;
  assign bus_be_o = st_reg.bus_be;
  assign bus_wdata_o = st_reg.bus_wdata;
  assign fetch_valid_o = st_reg.fetch_valid;
  assign fetch_addr_o = st_reg.fetch_addr;
  assign fetch_fault_o = st_reg.fetch_fault;
  assign instr_valid_o = st_reg.instr_valid;
  assign instr_o = st_reg.instr;
  assign pc_valid_o = st_reg.pc_valid;
  assign pc_o = st_reg.pc;
  assign invalid_state_o = st_reg.invalid;
  assign hard_fault_o = st_reg.hard_fault;
  assign lockup_o = st_reg.lockup;
  assign big_endian_o = st_reg.big;
endmodule

// ==== testbench/lsae_core_properties.sv ====
// concurrent checks on the ports of the load/store alignment and endian core
`timescale 1ns/1ps
module lsae_core_properties
  import lsae_pkg::*;
#(
  parameter logic [31:0] EXEC_NEVER_BASE = EXEC_NEVER_BASE_DEF
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // data request and bus
  input wire logic req_valid_i,
  input wire logic req_multi_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_base_i,
  input wire logic [31:0] req_offset_i,
  input wire logic [CNT_W-1:0] req_count_i,
  input wire logic req_ready_o,
  input wire logic [CNT_W-1:0] beat_o,
  input wire logic align_fault_o,
  input wire logic bus_valid_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [1:0] bus_size_o,
  input wire logic bus_ready_i,
  // fetch and program counter
  input wire logic fetch_req_i,
  input wire logic [31:0] fetch_pc_i,
  input wire logic fetch_valid_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic fetch_fault_o,
  input wire logic pc_wr_i,
  input wire logic [1:0] pc_src_i,
  input wire logic [31:0] pc_val_i,
  input wire logic exec_i,
  input wire logic in_hard_fault_i,
  input wire logic [31:0] pc_o,
  input wire logic invalid_state_o,
  input wire logic hard_fault_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic take;
  logic [31:0] addr;
  // accepted request and its wrapped address
  assign take = req_valid_i && req_ready_o;
  assign addr = 32'(req_base_i + req_offset_i);
  // ==========================================
  // alignment faults and bus beats
  a_half_fault: assert property (take && !req_multi_i && req_size_i == SZ_HALF && addr[0]
    |=> align_fault_o && !bus_valid_o) else $error("odd halfword not faulted");
  a_word_fault: assert property (take && !req_multi_i && req_size_i == SZ_WORD && addr[1:0] != 2'h0
    |=> align_fault_o && !bus_valid_o) else $error("unaligned word not faulted");
  a_multi_fault: assert property (take && req_multi_i && req_count_i != 0 && addr[1:0] != 2'h0
    |=> align_fault_o && !bus_valid_o) else $error("unaligned multiple not faulted");
  a_bus_natural: assert property (bus_valid_o && bus_size_o != SZ_BYTE
    |-> !bus_addr_o[0] && (bus_size_o != SZ_WORD || !bus_addr_o[1])) else $error("unaligned bus beat");
  a_multi_step: assert property ((bus_valid_o && bus_ready_i) ##1 (bus_valid_o && beat_o != 0)
    |-> bus_addr_o == $past(bus_addr_o) + WORD_STEP) else $error("multiple beat step wrong");
  // ==========================================
  // fetch and program counter
  a_fetch_even: assert property (fetch_req_i && fetch_pc_i < EXEC_NEVER_BASE
    |=> fetch_valid_o && fetch_addr_o == ($past(fetch_pc_i) & 32'hFFFF_FFFE)) else $error("fetch address odd");
  a_fetch_exec_never: assert property (fetch_req_i && fetch_pc_i >= EXEC_NEVER_BASE
    |=> fetch_fault_o && !fetch_valid_o) else $error("fetch in top region not refused");
  a_pc_ignore: assert property (pc_wr_i && pc_src_i == PCSRC_ALU
    |=> pc_o == ($past(pc_val_i) & 32'hFFFF_FFFE) && !invalid_state_o) else $error("pc bit 0 not ignored");
  a_pc_invalid: assert property (pc_wr_i && pc_src_i != PCSRC_ALU && !pc_val_i[0]
    |=> invalid_state_o) else $error("even target not invalid");
  a_exec_fault: assert property (exec_i && invalid_state_o && !in_hard_fault_i
    |=> hard_fault_o) else $error("invalid execution without hard fault");
endmodule
bind lsae_core lsae_core_properties #(.EXEC_NEVER_BASE(EXEC_NEVER_BASE)) u_props (.clock_i, .resetn_i, .req_valid_i,
  .req_multi_i, .req_size_i, .req_base_i, .req_offset_i, .req_count_i, .req_ready_o, .beat_o, .align_fault_o,
  .bus_valid_o, .bus_addr_o, .bus_size_o, .bus_ready_i, .fetch_req_i, .fetch_pc_i, .fetch_valid_o,
  .fetch_addr_o, .fetch_fault_o, .pc_wr_i, .pc_src_i, .pc_val_i, .exec_i, .in_hard_fault_i, .pc_o,
  .invalid_state_o, .hard_fault_o);

// ==== testbench/lsae_mem_model.sv ====
// behavioural system memory on the far side of the core's data bus
`timescale 1ns/1ps
module lsae_mem_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // bus from the core
  input wire logic bus_valid_i,
  input wire logic bus_write_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [3:0] bus_be_i,
  input wire logic [31:0] bus_wdata_i,
  output logic bus_ready_o,
  output logic bus_rvalid_o,
  output logic [31:0] bus_rdata_o
);
  logic [7:0] mem [logic [31:0]];
  logic [7:0] lfsr_reg;
  logic [31:0] w, rd;
  // pseudo-random stall, so beats are taken promptly or slowly
  assign bus_ready_o = bus_valid_i && !lfsr_reg[0];
  // one byte per address, lane k holds address low bits k; idle read data toggles
  always @(posedge clock_i) begin
    lfsr_reg <= !resetn_i ? 8'hA5 : {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]};
    bus_rvalid_o <= resetn_i && bus_ready_o && !bus_write_i;
    if (resetn_i && bus_ready_o) begin
      w = {bus_addr_i[31:2], 2'h0};
      for (int k = 0; k < 4; k++) begin
        if (bus_write_i && bus_be_i[k]) mem[w + k] = bus_wdata_i[8*k +: 8];
        rd[8*k +: 8] = mem.exists(w + k) ? mem[w + k] : w[7:0];
      end
      bus_rdata_o <= rd;
    end else begin
      bus_rdata_o <= !resetn_i ? 32'h0 : ~bus_rdata_o;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the load/store alignment and endian core
`timescale 1ns/1ps
module tb;
  import lsae_pkg::*;
  logic clock_i = 1'b0, resetn_i = 1'b0, endian_big_i, req_valid_i, req_write_i, req_multi_i, req_signed_i;
  logic [1:0] req_size_i, pc_src_i, bus_size_o;
  logic [31:0] req_base_i, req_offset_i, wdata_i, bus_rdata_i, fetch_pc_i, fetch_rdata_i, pc_val_i, sdata, rs, adr;
  logic [CNT_W-1:0] req_count_i, beat_o;
  logic bus_ready_i, bus_rvalid_i, fetch_req_i, fetch_rvalid_i, pc_wr_i, exec_i, in_hard_fault_i, bigx;
  logic req_ready_o, rd_valid_o, align_fault_o, bus_valid_o, bus_write_o, fetch_valid_o, fetch_fault_o;
  logic instr_valid_o, pc_valid_o, invalid_state_o, hard_fault_o, lockup_o, big_endian_o;
  logic [31:0] rd_data_o, fault_addr_o, bus_addr_o, bus_wdata_o, fetch_addr_o, instr_o, pc_o;
  logic [3:0] bus_be_o;
  logic [31:0] mdata [0:31];
  logic [31:0] rq [$];
  logic [7:0] refm [logic [31:0]];
  int err_count = 0, checks_done = 0, cyc = 0;
  // ==========================================
  // design, memory and clock
  lsae_core uut (.clock_i, .resetn_i, .endian_big_i, .req_valid_i, .req_write_i, .req_multi_i, .req_signed_i,
    .req_size_i, .req_base_i, .req_offset_i, .req_count_i, .wdata_i, .req_ready_o, .beat_o, .rd_valid_o,
    .rd_data_o, .align_fault_o, .fault_addr_o, .bus_valid_o, .bus_write_o, .bus_addr_o, .bus_size_o, .bus_be_o,
    .bus_wdata_o, .bus_ready_i, .bus_rvalid_i, .bus_rdata_i, .fetch_req_i, .fetch_pc_i, .fetch_rvalid_i,
    .fetch_rdata_i, .fetch_valid_o, .fetch_addr_o, .fetch_fault_o, .instr_valid_o, .instr_o, .pc_wr_i, .pc_src_i,
    .pc_val_i, .exec_i, .in_hard_fault_i, .pc_valid_o, .pc_o, .invalid_state_o, .hard_fault_o, .lockup_o,
    .big_endian_o);
  lsae_mem_model mem (.clock_i, .resetn_i, .bus_valid_i(bus_valid_o), .bus_write_i(bus_write_o),
    .bus_addr_i(bus_addr_o), .bus_be_i(bus_be_o), .bus_wdata_i(bus_wdata_o), .bus_ready_o(bus_ready_i),
    .bus_rvalid_o(bus_rvalid_i), .bus_rdata_o(bus_rdata_i));
  always #2.5 clock_i = ~clock_i;
  // next register of a multiple store must be ready while the current beat is taken
  assign wdata_i = req_multi_i ? mdata[req_ready_o ? 0 : beat_o + 1] : sdata;
  // collect load results and cut a hang short
  always @(posedge clock_i) begin
    if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one single or multiple transfer, checked beat by beat against the reference bytes
  task automatic xfer(input logic w, mu, sg, input logic [1:0] sz, input logic [31:0] a, d, input int n);
    logic [31:0] e, bw, m, ba, val;
    logic [3:0] be;
    logic eb;
    int nb, k, j, t, ix;
    nb = mu ? 4 : 1 << sz;
    eb = bigx && !(a >= PERIPH_BASE_DEF && a <= PERIPH_LAST_DEF);
    rq.delete();
    req_offset_i = rnd();
    req_base_i = a - req_offset_i;
    {req_write_i, req_multi_i, req_signed_i, req_size_i, req_count_i, sdata} = {w, mu, sg, sz, n[4:0], d};
    req_valid_i = 1'b1;
    @(posedge clock_i); #1;
    req_valid_i = 1'b0;
    chk("fault", align_fault_o, (a & (nb - 1)) != 0);
    if (align_fault_o === 1'b1) begin
      chk("fault_addr", {fault_addr_o[31:1], bus_valid_o}, {a[31:1], 1'b0});
      return;
    end
    for (k = 0; k < (mu ? n : 1); k++) begin
      ba = a + 4 * k;
      e = mu ? mdata[k] : d;
      chk("addr", {bus_valid_o, bus_addr_o, bus_write_o, bus_size_o, beat_o}, {1'b1, ba, w, mu ? SZ_WORD : sz, k[4:0]});
      {bw, m, be} = '0;
      for (j = 0; j < nb; j++) begin
        ix = eb ? nb - 1 - j : j;
        bw[8 * (ba[1:0] + j) +: 8] = e[8 * ix +: 8];
        m[8 * (ba[1:0] + j) +: 8] = 8'hFF;
        be[ba[1:0] + j] = 1'b1;
        if (w) refm[ba + j] = e[8 * ix +: 8];
      end
      if (w) chk("lanes", {bus_wdata_o & m, 28'h0, bus_be_o}, {bw, 28'h0, be});
      t = 0;
      while (bus_ready_i !== 1'b1 && t < 50) begin
        @(posedge clock_i); #1;
        t++;
      end
      chk("beat_taken", t < 50, 1);
      @(posedge clock_i); #1;
    end
    t = 0;
    while (!w && rq.size() < (mu ? n : 1) && t < 10) begin
      @(posedge clock_i); #1;
      t++;
    end
    for (k = 0; k < (mu ? n : 1) && !w; k++) begin
      val = '0;
      for (j = 0; j < nb; j++) val[8 * (eb ? nb - 1 - j : j) +: 8] = refm[a + 4 * k + j];
      if (nb == 1) val = {{24{sg & val[7]}}, val[7:0]};
      if (nb == 2) val = {{16{sg & val[15]}}, val[15:0]};
      chk("rdata", rq.size() > k ? rq[k] : ~val, val);
    end
  endtask
  // fetch, instruction return, pc write and execution in one go
  task automatic misc();
    logic [31:0] v;
    logic [1:0] s;
    v = rnd();
    s = v[5:4] % 3;
    {fetch_req_i, fetch_rvalid_i, pc_wr_i, pc_src_i, pc_val_i, fetch_rdata_i} = {3'h7, s, v, ~v};
    fetch_pc_i = v[6] ? {4'hF, v[27:0]} : v;
    @(posedge clock_i); #1;
    {fetch_req_i, fetch_rvalid_i, pc_wr_i, exec_i} = 4'h1;
    chk("fetch", {fetch_fault_o, fetch_valid_o}, fetch_pc_i >= EXEC_NEVER_BASE_DEF ? 2'h2 : 2'h1);
    if (fetch_valid_o) chk("fetch_addr", fetch_addr_o, fetch_pc_i & 32'hFFFF_FFFE);
    chk("instr", {instr_o, instr_valid_o}, {~v, 1'b1});
    chk("pc", {pc_o[31:1], invalid_state_o, pc_valid_o}, {v[31:1], s != PCSRC_ALU && !v[0], 1'b1});
    @(posedge clock_i); #1;
    {exec_i, pc_wr_i, pc_src_i} = {2'h1, PCSRC_ALU};
    chk("hard_fault", hard_fault_o, s != PCSRC_ALU && !v[0]);
    @(posedge clock_i); #1;
    pc_wr_i = 1'b0;
  endtask
  // ==========================================
  // main sequence: one pass per strap setting
  initial begin
    rs = 32'h691aa4af;
    {endian_big_i, req_valid_i, fetch_req_i, fetch_rvalid_i, pc_wr_i, exec_i, in_hard_fault_i} = '0;
    {req_base_i, req_offset_i, req_count_i, fetch_pc_i, pc_val_i, fetch_rdata_i, pc_src_i, sdata} = '0;
    {req_write_i, req_multi_i, req_signed_i, req_size_i} = '0;
    for (int ph = 0; ph < 2; ph++) begin
      {resetn_i, endian_big_i, bigx, in_hard_fault_i} = {1'b0, ph[0], ph[0], 1'b0};
      repeat (6) @(posedge clock_i);
      #1 resetn_i = 1'b1;
      chk("strap", {big_endian_o, lockup_o, req_ready_o}, {bigx, 2'h1});
      for (int k = 0; k < 32; k++) mdata[k] = rnd();
      xfer(1, 0, 0, SZ_HALF, 32'h2000_0001, rnd(), 1);
      xfer(1, 0, 0, SZ_WORD, 32'h2000_0002, rnd(), 1);
      xfer(1, 1, 0, SZ_BYTE, 32'hFFFF_FFF8, 0, 3);
      xfer(0, 1, 0, SZ_BYTE, 32'hFFFF_FFF8, 0, 3);
      xfer(1, 1, 0, SZ_BYTE, 32'h2000_0006, 0, 2);
      for (int i = 0; i < 40; i++) begin
        rs = rnd();
        adr = 32'((rs[0] ? PERIPH_BASE_DEF : 32'h2000_0000) + {rs[10:2], 2'h0});
        xfer(1, 0, 0, SZ_WORD, adr, rnd(), 1);
        xfer(1, 0, 0, rs[12:11] % 3, adr + rs[14:13], rnd(), 1);
        xfer(0, 0, rs[15], rs[17:16] % 3, adr + rs[19:18], 0, 1);
        misc();
      end
      {pc_wr_i, pc_src_i, pc_val_i} = {1'b1, PCSRC_XCHG, 32'h0000_1000};
      @(posedge clock_i); #1;
      {pc_wr_i, exec_i, in_hard_fault_i} = 3'h3;
      @(posedge clock_i); #1;
      exec_i = 1'b0;
      @(posedge clock_i); #1;
      chk("lockup", lockup_o, 1);
    end
    end_of_test();
  end
endmodule
